// file: hw/hbo_pkg.sv
// Package with register map, field positions and reset values.
package hbo_pkg;
    // ========================================
    // Register indices; byte address is four times the index.
    localparam logic [5:0] IDX_BRIDGE_OUT  = 6'h01;
    localparam logic [5:0] IDX_BRIDGE_STAT = 6'h03;
    localparam logic [5:0] IDX_MUX_CTL     = 6'h08;
    localparam logic [5:0] IDX_SYS_CTL     = 6'h0c;
    localparam logic [5:0] IDX_IRQ_FLAG    = 6'h0d;
    localparam logic [5:0] IDX_IRQ_MASK    = 6'h0e;
    // ========================================
    // Field positions.
    localparam int NUM_BRIDGES      = 4;
    localparam int POS_RECIRC       = 7;
    localparam int POS_SENSE_GAIN   = 4;
    localparam int POS_STAGE_EN     = 0;
    localparam int POS_OT_SEL       = 1;
    localparam int POS_VOLT_INHIBIT = 3;
    localparam int POS_HARD_TRIP    = 7;
    localparam int POS_OT_FLAG      = 0;
    localparam int POS_UV_FLAG      = 1;
    localparam int POS_OV_FLAG      = 2;
    localparam int POS_OT_MASK      = 0;
    // ========================================
    // Reset values.
    localparam logic [7:0] RST_BRIDGE_OUT = 8'h00;
    localparam logic [1:0] RST_OT_SEL     = 2'h0;
endpackage

// file: hw/hbo_bridge_if.sv
// Interface joining the control core to one half-bridge slice.
`timescale 1ns/1ps
interface hbo_bridge_if;
    logic high_select;
    logic low_select;
    logic stage_enable;
    logic recirc;
    logic pwm;
    logic oc_high;
    logic oc_low;
    logic high_gate_low;
    logic low_gate_low;
    logic oc_clear;
    logic oc_flag;
    logic high_on;
    logic low_on;
    modport ctl (output high_select, low_select, stage_enable, recirc, pwm,
                 oc_high, oc_low, high_gate_low, low_gate_low, oc_clear,
                 input oc_flag, high_on, low_on);
    modport bridge (input high_select, low_select, stage_enable, recirc, pwm,
                    oc_high, oc_low, high_gate_low, low_gate_low, oc_clear,
                    output oc_flag, high_on, low_on);
endinterface

// file: hw/hbo_bridge.sv
// One half-bridge slice: mode decode, interlock and over-current latch.
`timescale 1ns/1ps
module hbo_bridge (
    input  wire logic    pclk,
    input  wire logic    presetn,
    hbo_bridge_if.bridge br
);
    logic want_high;
    logic want_low;
    logic high_dis;
    logic low_dis;
    logic pwm_mode;

    // ========================================
    // Over-current latches; a new event wins over a clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_dis <= 1'b0;
            low_dis  <= 1'b0;
        end else begin
            high_dis <= (high_dis & ~br.oc_clear) | br.oc_high; // R14 R15 R20
            low_dis  <= (low_dis & ~br.oc_clear) | br.oc_low;   // R14 R15 R20
        end
    end
    assign br.oc_flag = high_dis | low_dis; // R14 R16

    // ========================================
    // Mode decode; both selects mean PWM, never dual conduction.
    always_comb begin
        pwm_mode  = br.high_select & br.low_select;                 // R2 R3
        want_high = pwm_mode ? br.pwm : br.high_select;              // R2 R5
        want_low  = pwm_mode ? (br.recirc & ~br.pwm) : br.low_select; // R6 R7
        want_high = want_high & br.stage_enable & ~high_dis & ~br.oc_high;
        want_low  = want_low & br.stage_enable & ~low_dis & ~br.oc_low;
    end

    // ========================================
    // Break-before-make: the opposite gate must be off and discharged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            br.high_on <= 1'b0;
            br.low_on  <= 1'b0;
        end else begin
            br.high_on <= want_high & ~br.low_on & br.low_gate_low; // R4
            br.low_on  <= want_low & ~br.high_on & br.high_gate_low & ~want_high; // R4
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    no_dual_on_a: assert property (!(br.high_on && br.low_on)) // R3
        else $error("Both gates of one bridge are on.");
    bbm_high_a: assert property ($rose(br.high_on) |-> // R4
        $past(br.low_gate_low) && !$past(br.low_on))
        else $error("High side turned on before low gate discharged.");
    pwm_follow_a: assert property (br.stage_enable && pwm_mode // R5
        && !high_dis && !br.oc_high && br.low_gate_low && !br.low_on
        |=> br.high_on == $past(br.pwm))
        else $error("High side does not follow the PWM input.");
    recirc_on_a: assert property (br.stage_enable && pwm_mode // R6
        && br.recirc && !br.pwm && !low_dis && !br.oc_low
        && br.high_gate_low && !br.high_on |=> br.low_on)
        else $error("Low side not on during PWM off time.");
    diode_only_a: assert property (pwm_mode && !br.recirc |=> !br.low_on) // R7
        else $error("Low side on in PWM without recirculation.");
    oc_trip_a: assert property (br.oc_high |=> br.oc_flag && !br.high_on) // R14
        else $error("High side over-current not latched.");
    oc_hold_a: assert property (br.oc_flag && !br.oc_clear |=> br.oc_flag) // R16
        else $error("Over-current flag dropped without a clear.");
    oc_clear_a: assert property (br.oc_flag && br.oc_clear // R15
        && !br.oc_high && !br.oc_low |=> !br.oc_flag)
        else $error("Over-current flag not cleared by write of one.");

    pwm_high_c: cover property (pwm_mode && br.high_on);
    recirc_c: cover property (pwm_mode && br.recirc && br.low_on);
    oc_trip_c: cover property ($rose(br.oc_flag));
endmodule

// file: hw/hbo_top.sv
// Half-bridge output control with APB register file and protection.
// ========================================
// Summary of operation
// R1: All bridge MOSFETs stay off unless power_stage_enable is set.
// R2: Selects decode: 00 off, low only, high only, 11 high-side PWM.
// R3: High and low of one bridge never conduct together.
// R4: A gate turns on only after the opposite gate reports discharged.
// R5: In PWM mode the high side follows the PWM input.
// R6: With recirc_mode set, low side is on while PWM high side is off.
// R7: With recirc_mode clear, low side stays off in PWM off time.
// R8: Reset clears bridge_output_reg, so all outputs start off.
// R9: sense_gain_select picks sense gain: 1 low, 0 high resolution.
// R10: First temperature threshold sets overtemp_warn_flag; masked interrupt.
// R11: If selected, overtemp_warn_flag turns off the power stages.
// R12: Write 1 or reset clears overtemp_warn_flag; useless while hot.
// R13: Warning shutdown disabled: second threshold turns every stage off.
// R14: Over-current switches that side off and sets the bridge flag.
// R15: Writing 1 clears bridge_overcurrent_flag and re-enables the bridge.
// R16: Writing 0 to bridge_overcurrent_flag changes nothing.
// R17: Voltage flag set and inhibit clear disables all bridge outputs.
// R18: Write 1 or reset clears voltage flags; useless while condition stays.
// R19: Status register: recirc bit 7, zeros 6..4, flags 3..0, reset 0.
// R20: Each protection shutdown is a latched disable until flag clear. The hard thermal trip has no flag and only reset releases it.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module hbo_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pwm_in,
    input  wire logic        overtemp_warn_cond,
    input  wire logic        overtemp_hard_cond,
    input  wire logic        undervolt_cond,
    input  wire logic        overvolt_cond,
    input  wire logic [3:0]  oc_high,
    input  wire logic [3:0]  oc_low,
    input  wire logic [3:0]  high_gate_low,
    input  wire logic [3:0]  low_gate_low,
    output logic      [3:0]  high_gate_on,
    output logic      [3:0]  low_gate_on,
    output logic             sense_gain_select,
    output logic             overtemp_irq
);
    localparam int NB = hbo_pkg::NUM_BRIDGES;

    logic [7:0] bridge_output_reg;
    logic       recirc_mode;
    logic       power_stage_enable;
    logic [1:0] overtemp_shutdown_select;
    logic       volt_shutdown_inhibit;
    logic       overtemp_irq_mask;
    logic       overtemp_warn_flag;
    logic       undervolt_flag;
    logic       overvolt_flag;
    logic       overtemp_hard_shutdown;
    logic [3:0] bridge_overcurrent_flag;
    logic       stage_enable;
    logic       ot_shut_en;

    logic       wr_en;
    logic       rd_setup;
    logic       addr_ok;
    logic [5:0] idx;
    logic [7:0] wbyte;
    logic [7:0] next_rdata;
    logic       hit;

    // ========================================
    // APB decode. Zero wait states; unmapped addresses answer an error.
    assign idx     = paddr[7:2];
    assign addr_ok = (paddr[1:0] == 2'h0);
    assign wbyte   = pwdata[7:0];
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite & hit & pstrb[0];
    assign rd_setup = psel & ~penable & ~pwrite;

    always_comb begin
        hit        = 1'b0;
        next_rdata = 8'h00;
        if (!addr_ok) begin
            hit = 1'b0;
        end else if (idx == hbo_pkg::IDX_BRIDGE_OUT) begin
            hit        = 1'b1;
            next_rdata = bridge_output_reg;
        end else if (idx == hbo_pkg::IDX_BRIDGE_STAT) begin
            hit        = 1'b1;
            next_rdata = {recirc_mode, 3'h0, bridge_overcurrent_flag}; // R19
        end else if (idx == hbo_pkg::IDX_MUX_CTL) begin
            hit = 1'b1;
            next_rdata[hbo_pkg::POS_SENSE_GAIN] = sense_gain_select;
        end else if (idx == hbo_pkg::IDX_SYS_CTL) begin
            hit = 1'b1;
            next_rdata[hbo_pkg::POS_STAGE_EN]     = power_stage_enable;
            next_rdata[hbo_pkg::POS_OT_SEL +: 2]  = overtemp_shutdown_select;
            next_rdata[hbo_pkg::POS_VOLT_INHIBIT] = volt_shutdown_inhibit;
            next_rdata[hbo_pkg::POS_HARD_TRIP]    = overtemp_hard_shutdown;
        end else if (idx == hbo_pkg::IDX_IRQ_FLAG) begin
            hit = 1'b1;
            next_rdata[hbo_pkg::POS_OT_FLAG] = overtemp_warn_flag;
            next_rdata[hbo_pkg::POS_UV_FLAG] = undervolt_flag;
            next_rdata[hbo_pkg::POS_OV_FLAG] = overvolt_flag;
        end else if (idx == hbo_pkg::IDX_IRQ_MASK) begin
            hit = 1'b1;
            next_rdata[hbo_pkg::POS_OT_MASK] = overtemp_irq_mask;
        end
    end

    assign pslverr = psel & penable & ~hit;

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            prdata <= {24'h0, next_rdata};
        end
    end

    // ========================================
    // Software control registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_output_reg <= hbo_pkg::RST_BRIDGE_OUT; // R8
        end else if (wr_en && idx == hbo_pkg::IDX_BRIDGE_OUT) begin
            bridge_output_reg <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recirc_mode <= 1'b0; // R19
        end else if (wr_en && idx == hbo_pkg::IDX_BRIDGE_STAT) begin
            recirc_mode <= wbyte[hbo_pkg::POS_RECIRC];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_gain_select <= 1'b0;
        end else if (wr_en && idx == hbo_pkg::IDX_MUX_CTL) begin
            sense_gain_select <= wbyte[hbo_pkg::POS_SENSE_GAIN]; // R9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_stage_enable       <= 1'b0;
            overtemp_shutdown_select <= hbo_pkg::RST_OT_SEL;
            volt_shutdown_inhibit    <= 1'b0;
        end else if (wr_en && idx == hbo_pkg::IDX_SYS_CTL) begin
            power_stage_enable       <= wbyte[hbo_pkg::POS_STAGE_EN];
            overtemp_shutdown_select <= wbyte[hbo_pkg::POS_OT_SEL +: 2];
            volt_shutdown_inhibit    <= wbyte[hbo_pkg::POS_VOLT_INHIBIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overtemp_irq_mask <= 1'b0;
        end else if (wr_en && idx == hbo_pkg::IDX_IRQ_MASK) begin
            overtemp_irq_mask <= wbyte[hbo_pkg::POS_OT_MASK];
        end
    end

    // ========================================
    // Protection flags. A live condition sets the flag every cycle, so a
    // write of one has no effect while the condition persists.
    logic clr_ot;
    logic clr_uv;
    logic clr_ov;
    assign clr_ot = wr_en && idx == hbo_pkg::IDX_IRQ_FLAG
                    && wbyte[hbo_pkg::POS_OT_FLAG];
    assign clr_uv = wr_en && idx == hbo_pkg::IDX_IRQ_FLAG
                    && wbyte[hbo_pkg::POS_UV_FLAG];
    assign clr_ov = wr_en && idx == hbo_pkg::IDX_IRQ_FLAG
                    && wbyte[hbo_pkg::POS_OV_FLAG];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overtemp_warn_flag <= 1'b0;
        end else begin
            overtemp_warn_flag <= (overtemp_warn_flag & ~clr_ot)
                                  | overtemp_warn_cond; // R10 R12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undervolt_flag <= 1'b0;
            overvolt_flag  <= 1'b0;
        end else begin
            undervolt_flag <= (undervolt_flag & ~clr_uv) | undervolt_cond; // R18
            overvolt_flag  <= (overvolt_flag & ~clr_ov) | overvolt_cond;   // R18
        end
    end

    assign ot_shut_en = (overtemp_shutdown_select != 2'h0);

    // The hard thermal trip has no flag of its own; only reset releases it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overtemp_hard_shutdown <= 1'b0;
        end else if (!ot_shut_en && overtemp_hard_cond) begin
            overtemp_hard_shutdown <= 1'b1; // R13 R20
        end
    end

    assign overtemp_irq = overtemp_warn_flag & overtemp_irq_mask; // R10

    // ========================================
    // Global stage enable from the master bit and the latched shutdowns.
    assign stage_enable = power_stage_enable                       // R1
        & ~(overtemp_warn_flag & ot_shut_en)                       // R11 R20
        & ~((undervolt_flag | overvolt_flag) & ~volt_shutdown_inhibit) // R17
        & ~overtemp_hard_shutdown;                                 // R13

    // ========================================
    // Bridge slices.
    hbo_bridge_if bif [NB] ();

    for (genvar i = 0; i < NB; i++) begin : g_br
        assign bif[i].high_select   = bridge_output_reg[2*i+1]; // R2
        assign bif[i].low_select    = bridge_output_reg[2*i];   // R2
        assign bif[i].stage_enable  = stage_enable;
        assign bif[i].recirc        = recirc_mode;
        assign bif[i].pwm           = pwm_in;
        assign bif[i].oc_high       = oc_high[i];
        assign bif[i].oc_low        = oc_low[i];
        assign bif[i].high_gate_low = high_gate_low[i];
        assign bif[i].low_gate_low  = low_gate_low[i];
        assign bif[i].oc_clear      = wr_en
            && idx == hbo_pkg::IDX_BRIDGE_STAT && wbyte[i]; // R15 R16
        assign bridge_overcurrent_flag[i] = bif[i].oc_flag;
        assign high_gate_on[i] = bif[i].high_on;
        assign low_gate_on[i]  = bif[i].low_on;

        hbo_bridge u_bridge (
            .pclk    (pclk),
            .presetn (presetn),
            .br      (bif[i])
        );
    end

    // ========================================
    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    master_off_a: assert property (!power_stage_enable // R1
        |=> high_gate_on == 4'h0 && low_gate_on == 4'h0)
        else $error("Gate on while power stage is disabled.");
    ot_flag_set_a: assert property (overtemp_warn_cond // R10
        |=> overtemp_warn_flag)
        else $error("Warning condition did not set its flag.");
    ot_irq_out_a: assert property (overtemp_warn_cond // R10
        && overtemp_irq_mask && !(wr_en && idx == hbo_pkg::IDX_IRQ_MASK)
        |=> overtemp_irq)
        else $error("Warning condition did not raise the interrupt.");
    ot_shutdown_a: assert property (overtemp_warn_flag && ot_shut_en // R11
        |=> high_gate_on == 4'h0 && low_gate_on == 4'h0)
        else $error("Warning shutdown left a gate on.");
    ot_clear_a: assert property (overtemp_warn_flag && clr_ot // R12
        && !overtemp_warn_cond |=> !overtemp_warn_flag)
        else $error("Warning flag not cleared by write of one.");
    hard_off_a: assert property (!ot_shut_en && overtemp_hard_cond // R13
        |=> ##1 high_gate_on == 4'h0 && low_gate_on == 4'h0)
        else $error("Hard thermal trip left a gate on.");
    volt_off_a: assert property ((undervolt_flag || overvolt_flag) // R17
        && !volt_shutdown_inhibit
        |=> high_gate_on == 4'h0 && low_gate_on == 4'h0)
        else $error("Voltage fault left a gate on.");
    volt_hold_a: assert property (undervolt_cond |=> undervolt_flag[*2]) // R18
        else $error("Under-voltage flag cleared while condition held.");

    volt_off_c: cover property (overvolt_flag && !volt_shutdown_inhibit);
    ot_irq_c: cover property (overtemp_irq);
endmodule

// file: test/hbo_gate_model.sv
// Power stage model that reports each gate discharged some time after off.
`timescale 1ns/1ps
module hbo_gate_model (
    input  wire logic       pclk,
    input  wire logic       slow,
    input  wire logic [3:0] high_on,
    input  wire logic [3:0] low_on,
    output logic      [3:0] high_low,
    output logic      [3:0] low_low
);
    // ========================================
    // Discharge timers
    // A slow gate makes the interlock wait several cycles, not just one.
    int hc [4];
    int lc [4];
    int lim;
    assign lim = slow ? 6 : 1;
    always @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            hc[i] <= high_on[i] ? 0 : hc[i] + 1;
            lc[i] <= low_on[i] ? 0 : lc[i] + 1;
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            high_low[i] = !high_on[i] && hc[i] >= lim;
            low_low[i]  = !low_on[i] && lc[i] >= lim;
        end
    end
endmodule

// file: test/half_bridge_output_control_test.sv
// Self-checking bench for the half-bridge output control block.
`timescale 1ns/1ps
module half_bridge_output_control_test;
    // ========================================
    // Signals and model state
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, oc_high, oc_low, high_gate_low, low_gate_low;
    logic [3:0]  high_gate_on, low_gate_on, ohd, old;
    logic        pwm_in, otw, oth, slow, sense_gain_select, overtemp_irq;
    logic [1:0]  vc, vf, osel;
    logic        err, en, inh, ot, hard, rc, mk, sg;
    logic [7:0]  ob;
    int          error_cnt, checks_done;

    hbo_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .pwm_in,
        .overtemp_warn_cond(otw), .overtemp_hard_cond(oth),
        .undervolt_cond(vc[0]), .overvolt_cond(vc[1]), .oc_high, .oc_low,
        .high_gate_low, .low_gate_low, .high_gate_on, .low_gate_on,
        .sense_gain_select, .overtemp_irq);
    hbo_gate_model PM (.pclk, .slow, .high_on(high_gate_on),
        .low_on(low_gate_on), .high_low(high_gate_low),
        .low_low(low_gate_low));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ========================================
    // Checking and bus tasks
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [5:0] idx,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: bus answer missing", $time);
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        cmp(rd, {24'h000000, e}, "register read");
        cmp({31'h0, err}, 32'h0, "mapped read error");
    endtask
    task automatic wsys();
        wr(hbo_pkg::IDX_SYS_CTL, {4'h0, inh, osel, en});
    endtask
    task automatic regs();
        rdc(hbo_pkg::IDX_BRIDGE_OUT, ob);
        rdc(hbo_pkg::IDX_BRIDGE_STAT, {rc, 3'h0, ohd | old});
        rdc(hbo_pkg::IDX_MUX_CTL, {3'h0, sg, 4'h0});
        rdc(hbo_pkg::IDX_SYS_CTL, {hard, 3'h0, inh, osel, en});
        rdc(hbo_pkg::IDX_IRQ_FLAG, {5'h00, vf, ot});
        rdc(hbo_pkg::IDX_IRQ_MASK, {7'h00, mk});
    endtask
    // Outputs are compared once settled, so the interlock delay is absorbed.
    task automatic gchk();
        logic [3:0] h, l;
        logic       sh;
        repeat (12) @(posedge pclk);
        sh = (ot && osel != 2'h0) || hard || ((|vf) && !inh);
        for (int b = 0; b < 4; b++) begin
            h[b] = en && !sh && !ohd[b] && ob[2*b+1] && (!ob[2*b] || pwm_in);
            l[b] = en && !sh && !old[b] && ob[2*b]
                   && (!ob[2*b+1] || (rc && !pwm_in));
        end
        cmp({28'h0, high_gate_on}, {28'h0, h}, "high gates");
        cmp({28'h0, low_gate_on}, {28'h0, l}, "low gates");
        cmp({31'h0, overtemp_irq}, {31'h0, ot && mk}, "irq");
        cmp({31'h0, sense_gain_select}, {31'h0, sg}, "gain");
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        {en, inh, ot, hard, rc, mk, sg, vf, osel, ob, ohd, old} = '0;
    endtask

    // Both gates of one bridge must never be seen on together.
    always @(negedge pclk) begin
        if (presetn === 1'b1 && (high_gate_on & low_gate_on) !== 4'h0) begin
            error_cnt++;
            $display("mismatch at %0t: dual conduction", $time);
        end
    end
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        $display("mismatch at %0t: run timeout", $time);
        end_sim();
    end

    // ========================================
    // Scenarios
    initial begin
        {presetn, psel, penable, pwrite, pwm_in, otw, oth, slow} = '0;
        {paddr, pwdata, pstrb, oc_high, oc_low, vc} = '0;
        pstrb = 4'hf;
        void'($urandom(32'h4135));
        do_reset();
        regs();
        apb(1'b0, 6'h3f, 8'h00);
        cmp({31'h0, err}, 32'h1, "unmapped error");
        ob = 8'haa;
        wr(hbo_pkg::IDX_BRIDGE_OUT, ob);
        gchk();
        en = 1'b1;
        wsys();
        gchk();
        for (int t = 0; t < 24; t++) begin
            ob = 8'($urandom());
            rc = 1'($urandom());
            slow <= 1'($urandom());
            pwm_in <= 1'($urandom());
            wr(hbo_pkg::IDX_BRIDGE_OUT, ob);
            wr(hbo_pkg::IDX_BRIDGE_STAT, {rc, 7'h00});
            gchk();
            pwm_in <= ~pwm_in;
            gchk();
        end
        // Over-current latches per side; a zero write must be ignored.
        ob = 8'h66;
        rc = 1'b0;
        wr(hbo_pkg::IDX_BRIDGE_OUT, ob);
        wr(hbo_pkg::IDX_BRIDGE_STAT, 8'h00);
        @(posedge pclk);
        oc_high <= 4'h1;
        oc_low <= 4'h2;
        @(posedge pclk);
        oc_high <= 4'h0;
        oc_low <= 4'h0;
        ohd = 4'h1;
        old = 4'h2;
        gchk();
        wr(hbo_pkg::IDX_BRIDGE_STAT, 8'h00);
        gchk();
        regs();
        wr(hbo_pkg::IDX_BRIDGE_STAT, 8'h01);
        ohd = 4'h0;
        gchk();
        rdc(hbo_pkg::IDX_BRIDGE_STAT, 8'h02);
        wr(hbo_pkg::IDX_BRIDGE_STAT, 8'h02);
        old = 4'h0;
        gchk();
        // Voltage flags: shutdown, stuck clear, inhibit, real clear.
        for (int k = 0; k < 2; k++) begin
            vc[k] <= 1'b1;
            vf[k] = 1'b1;
            gchk();
            wr(hbo_pkg::IDX_IRQ_FLAG, 8'(2 << k));
            gchk();
            inh = 1'b1;
            wsys();
            gchk();
            inh = 1'b0;
            wsys();
            vc[k] <= 1'b0;
            wr(hbo_pkg::IDX_IRQ_FLAG, 8'(2 << k));
            vf[k] = 1'b0;
            gchk();
        end
        // Thermal warning with each nonzero shutdown selection, 1 to 3.
        mk = 1'b1;
        wr(hbo_pkg::IDX_IRQ_MASK, 8'h01);
        for (int s = 1; s < 4; s++) begin
            osel = 2'(s);
            wsys();
            otw <= 1'b1;
            ot = 1'b1;
            gchk();
            wr(hbo_pkg::IDX_IRQ_FLAG, 8'h01);
            gchk();
            otw <= 1'b0;
            wr(hbo_pkg::IDX_IRQ_FLAG, 8'h01);
            ot = 1'b0;
            gchk();
        end
        sg = 1'b1;
        wr(hbo_pkg::IDX_MUX_CTL, 8'h10);
        gchk();
        // Hard thermal trip with the warning shutdown disabled.
        osel = 2'h0;
        wsys();
        otw <= 1'b1;
        oth <= 1'b1;
        ot = 1'b1;
        hard = 1'b1;
        gchk();
        regs();
        otw <= 1'b0;
        oth <= 1'b0;
        do_reset();
        regs();
        gchk();
        end_sim();
    end
endmodule
